// ---- hdl/fmr_pkg.sv ----
// Constants shared by the fault monitor: register map, field positions,
// reset values and serial frame layout.
// Assumes a single 100 MHz core clock and an 8-bit register space.
package fmr_pkg;

  // Register offsets on the serial programming port.
  localparam logic [6:0] FMR_ADDR_STATUS   = 7'h0C;
  localparam logic [6:0] FMR_ADDR_CONFIG   = 7'h0D;
  localparam logic [6:0] FMR_ADDR_WARN_THR = 7'h10;
  localparam logic [6:0] FMR_ADDR_CUT_THR  = 7'h11;

  // Bit positions inside the fault status and config registers.
  localparam int FMR_BIT_SUPPLY   = 0;
  localparam int FMR_BIT_ILLUM    = 1;
  localparam int FMR_BIT_MIRROR   = 2;
  localparam int FMR_BIT_POWER    = 3;
  localparam int FMR_BIT_IN_WARN  = 4;
  localparam int FMR_BIT_IN_CUT   = 5;
  localparam int FMR_BIT_HOT_WARN = 6;
  localparam int FMR_BIT_HOT_CUT  = 7;

  // Threshold fields are five bits wide in the low part of the register.
  localparam int FMR_THR_W = 5;

  // Reset values.
  localparam logic [7:0]           FMR_RST_STATUS   = 8'h00;
  localparam logic [7:0]           FMR_RST_CONFIG   = 8'hFF;
  localparam logic [FMR_THR_W-1:0] FMR_RST_WARN_THR = 5'h14;
  localparam logic [FMR_THR_W-1:0] FMR_RST_CUT_THR  = 5'h10;

  // Serial frame: one command byte (write flag, address) then one data byte.
  localparam int         FMR_CMD_WR_BIT  = 7;
  localparam logic [4:0] FMR_CNT_CMD_END = 5'h07;
  localparam logic [4:0] FMR_CNT_FRM_END = 5'h0F;
  localparam logic [4:0] FMR_CNT_DATA    = 5'h08;

  // Number of asynchronous level inputs passed through the synchroniser.
  localparam int FMR_NSYNC = 16;

  // Synchroniser reset image: chip select inactive, supply level at full
  // scale, so the first cycles after reset show no low-input condition.
  localparam logic [FMR_NSYNC-1:0] FMR_RST_SYNC = 16'h81F0;

endpackage

// ---- hdl/fmr_fault_monitor.sv ----
// Fault monitor and reporter with its serial register port.
// Assumes the comparator and pin inputs are asynchronous to CLK and the
// serial clock is slower than a sixth of CLK.
//
// Functional notes
// - Fault type is held in the status register at 0x0C.
// - Interrupt output asserts whenever any fault enabled in the config register occurs.
// - Config register at 0x0D, writable, chooses which faults interrupt.
// - Supply, illumination and mirror-array faults each own a flag.
// - A status bit records that the power request pin was asserted.
// - Input below warning threshold raises the low-input warning flag.
// - Input below cutoff threshold flags the cause and shuts down.
// - Warning and cutoff thresholds are 5-bit fields at 0x10 and 0x11.
// - Status reports overheat warning and overheat cutoff separately.
// - Reaching the overheat cutoff level shuts the device down.
// - Both temperature indications use hysteresis against toggling.
`timescale 1ns/1ps
`default_nettype none

module fmr_fault_monitor
  import fmr_pkg::*;
(
  // Clock, reset and clock enable.
  input  wire logic                 CLK,
  input  wire logic                 RESETN,
  input  wire logic                 CE,
  // Serial programming port.
  input  wire logic                 SPI_CSZ_N,
  input  wire logic                 SPI_CLK,
  input  wire logic                 SPI_DIN,
  output logic                      SPI_DOUT,
  output logic                      SPI_DOUT_OE,
  // Block fault comparators.
  input  wire logic                 SUPPLY_FAULT_IN,
  input  wire logic                 ILLUM_FAULT_IN,
  input  wire logic                 MIRROR_FAULT_IN,
  // Power-on request pin.
  input  wire logic                 POWER_REQUEST_PIN,
  // Quantised input supply level, same scale as the threshold fields.
  input  wire logic [FMR_THR_W-1:0] INPUT_LEVEL,
  // Temperature comparators: above trip point, below release point.
  input  wire logic                 HOT_WARN_TRIP,
  input  wire logic                 HOT_WARN_RELEASE,
  input  wire logic                 HOT_CUT_TRIP,
  input  wire logic                 HOT_CUT_RELEASE,
  // Reporting and protection outputs.
  output logic                      INTERRUPT,
  output logic                      SHUTDOWN
);

  // Read decode, used for the serial read path.
  function automatic logic [7:0] reg_read(
    input logic [6:0]           addr,
    input logic [7:0]           status,
    input logic [7:0]           config_v,
    input logic [FMR_THR_W-1:0] warn,
    input logic [FMR_THR_W-1:0] cut
  );
    logic [7:0] v;
    v = 8'h00;
    unique case (addr)
      FMR_ADDR_STATUS:   v = status;
      FMR_ADDR_CONFIG:   v = config_v;
      FMR_ADDR_WARN_THR: v = {3'h0, warn};
      FMR_ADDR_CUT_THR:  v = {3'h0, cut};
      default:           v = 8'h00;
    endcase
    return v;
  endfunction

  // Synchroniser group: two stages, the first read only by the second.
  logic [FMR_NSYNC-1:0] meta_r;
  logic [FMR_NSYNC-1:0] meta_nxt;
  logic [FMR_NSYNC-1:0] sync_r;
  logic [FMR_NSYNC-1:0] sync_nxt;
  logic [FMR_NSYNC-1:0] raw;

  assign raw = {SPI_CSZ_N, SPI_CLK, SPI_DIN, SUPPLY_FAULT_IN,
                ILLUM_FAULT_IN, MIRROR_FAULT_IN, POWER_REQUEST_PIN,
                INPUT_LEVEL, HOT_WARN_TRIP, HOT_WARN_RELEASE,
                HOT_CUT_TRIP, HOT_CUT_RELEASE};

  // Next values of the synchroniser; reset loads the idle levels, because a
  // zero supply code would latch a false cutoff before the pins arrive.
  always_comb
  begin
    meta_nxt = meta_r;
    sync_nxt = sync_r;
    if (!RESETN)
    begin
      meta_nxt = FMR_RST_SYNC;
      sync_nxt = FMR_RST_SYNC;
    end
    else if (CE)
    begin
      meta_nxt = raw;
      sync_nxt = meta_r;
    end
  end

  // Synchroniser registers.
  always_ff @(posedge CLK)
  begin
    meta_r <= meta_nxt;
    sync_r <= sync_nxt;
  end

  // Named views of the synchronised levels.
  logic                 cs_n_s;
  logic                 sclk_s;
  logic                 din_s;
  logic                 supply_s;
  logic                 illum_s;
  logic                 mirror_s;
  logic                 power_s;
  logic [FMR_THR_W-1:0] level_s;
  logic                 hw_trip_s;
  logic                 hw_rel_s;
  logic                 hc_trip_s;
  logic                 hc_rel_s;

  assign {cs_n_s, sclk_s, din_s, supply_s, illum_s, mirror_s, power_s,
          level_s, hw_trip_s, hw_rel_s, hc_trip_s, hc_rel_s} = sync_r;

  // Serial port state.
  logic [4:0] bit_cnt_r;
  logic [4:0] bit_cnt_nxt;
  logic [6:0] shift_in_r;
  logic [6:0] shift_in_nxt;
  logic [7:0] shift_out_r;
  logic [7:0] shift_out_nxt;
  logic [6:0] addr_r;
  logic [6:0] addr_nxt;
  logic       wr_r;
  logic       wr_nxt;
  logic       dout_r;
  logic       dout_nxt;
  logic       sclk_d_r;
  logic       sclk_d_nxt;
  // Register file and fault state.
  logic [7:0]           status_r;
  logic [7:0]           status_nxt;
  logic [7:0]           config_r;
  logic [7:0]           config_nxt;
  logic [FMR_THR_W-1:0] warn_thr_r;
  logic [FMR_THR_W-1:0] warn_thr_nxt;
  logic [FMR_THR_W-1:0] cut_thr_r;
  logic [FMR_THR_W-1:0] cut_thr_nxt;
  logic                 power_d_r;
  logic                 power_d_nxt;
  logic                 hot_warn_r;
  logic                 hot_warn_nxt;
  logic                 hot_cut_r;
  logic                 hot_cut_nxt;
  logic                 shutdown_r;
  logic                 shutdown_nxt;

  // Decoded serial events and register strobes.
  logic       sclk_rise;
  logic       sclk_fall;
  logic [7:0] byte_in;
  logic       cmd_done;
  logic       wr_strobe;
  logic [7:0] clr_mask;
  logic [7:0] events;

  assign sclk_rise = CE & ~cs_n_s & sclk_s & ~sclk_d_r;
  assign sclk_fall = CE & ~cs_n_s & ~sclk_s & sclk_d_r;
  assign byte_in   = {shift_in_r, din_s};
  assign cmd_done  = sclk_rise & (bit_cnt_r == FMR_CNT_CMD_END);
  assign wr_strobe = sclk_rise & wr_r & (bit_cnt_r == FMR_CNT_FRM_END);

  // A read of the status register clears exactly the bits it returned.
  assign clr_mask = (cmd_done & ~byte_in[FMR_CMD_WR_BIT] &
                     (byte_in[6:0] == FMR_ADDR_STATUS)) ? status_r : 8'h00;

  // Serial port next state: mode 0, sample on rise, shift out on fall.
  always_comb
  begin
    bit_cnt_nxt   = bit_cnt_r;
    shift_in_nxt  = shift_in_r;
    shift_out_nxt = shift_out_r;
    addr_nxt      = addr_r;
    wr_nxt        = wr_r;
    dout_nxt      = dout_r;
    sclk_d_nxt    = sclk_d_r;
    if (!RESETN)
    begin
      bit_cnt_nxt   = 5'h00;
      shift_in_nxt  = 7'h00;
      shift_out_nxt = 8'h00;
      addr_nxt      = 7'h00;
      wr_nxt        = 1'b0;
      dout_nxt      = 1'b0;
      sclk_d_nxt    = 1'b0;
    end
    else if (CE)
    begin
      sclk_d_nxt = sclk_s;
      if (cs_n_s)
      begin
        // Deselect aborts any partial frame, so a short frame writes nothing.
        bit_cnt_nxt = 5'h00;
        wr_nxt      = 1'b0;
      end
      else
      begin
        if (sclk_rise)
        begin
          shift_in_nxt = byte_in[6:0];
          if (bit_cnt_r != FMR_CNT_FRM_END + 5'h01)
            bit_cnt_nxt = bit_cnt_r + 5'h01;
          if (cmd_done)
          begin
            wr_nxt        = byte_in[FMR_CMD_WR_BIT];
            addr_nxt      = byte_in[6:0];
            shift_out_nxt = reg_read(byte_in[6:0], status_r, config_r,
                                     warn_thr_r, cut_thr_r);
          end
        end
        if (sclk_fall && bit_cnt_r >= FMR_CNT_DATA)
        begin
          dout_nxt      = shift_out_r[7];
          shift_out_nxt = {shift_out_r[6:0], 1'b0};
        end
      end
    end
  end

  // Serial port registers.
  always_ff @(posedge CLK)
  begin
    bit_cnt_r   <= bit_cnt_nxt;
    shift_in_r  <= shift_in_nxt;
    shift_out_r <= shift_out_nxt;
    addr_r      <= addr_nxt;
    wr_r        <= wr_nxt;
    dout_r      <= dout_nxt;
    sclk_d_r    <= sclk_d_nxt;
  end

  // Fault events seen this cycle; sticky bits collect them below.
  always_comb
  begin
    events                   = 8'h00;
    events[FMR_BIT_SUPPLY]   = supply_s;
    events[FMR_BIT_ILLUM]    = illum_s;
    events[FMR_BIT_MIRROR]   = mirror_s;
    events[FMR_BIT_POWER]    = power_s & ~power_d_r;
    events[FMR_BIT_IN_WARN]  = level_s < warn_thr_r;
    events[FMR_BIT_IN_CUT]   = level_s < cut_thr_r;
    events[FMR_BIT_HOT_WARN] = hot_warn_r;
    events[FMR_BIT_HOT_CUT]  = hot_cut_r;
  end

  // Register file and fault state next values.
  always_comb
  begin
    status_nxt   = status_r;
    config_nxt   = config_r;
    warn_thr_nxt = warn_thr_r;
    cut_thr_nxt  = cut_thr_r;
    power_d_nxt  = power_d_r;
    hot_warn_nxt = hot_warn_r;
    hot_cut_nxt  = hot_cut_r;
    shutdown_nxt = shutdown_r;
    if (!RESETN)
    begin
      status_nxt   = FMR_RST_STATUS;
      config_nxt   = FMR_RST_CONFIG;
      warn_thr_nxt = FMR_RST_WARN_THR;
      cut_thr_nxt  = FMR_RST_CUT_THR;
      power_d_nxt  = 1'b0;
      hot_warn_nxt = 1'b0;
      hot_cut_nxt  = 1'b0;
      shutdown_nxt = 1'b0;
    end
    else if (CE)
    begin
      power_d_nxt = power_s;
      // Trip on the upper comparator, release only below the lower one.
      if (hw_trip_s)
        hot_warn_nxt = 1'b1;
      else if (hw_rel_s)
        hot_warn_nxt = 1'b0;
      if (hc_trip_s)
        hot_cut_nxt = 1'b1;
      else if (hc_rel_s)
        hot_cut_nxt = 1'b0;
      // A new event wins over a clear in the same cycle.
      status_nxt = (status_r & ~clr_mask) | events;
      // Shutdown latches until reset; a brief dip must not restart.
      if (events[FMR_BIT_IN_CUT] || events[FMR_BIT_HOT_CUT])
        shutdown_nxt = 1'b1;
      if (wr_strobe)
      begin
        unique case (addr_r)
          FMR_ADDR_CONFIG:   config_nxt   = byte_in;
          FMR_ADDR_WARN_THR: warn_thr_nxt = byte_in[FMR_THR_W-1:0];
          FMR_ADDR_CUT_THR:  cut_thr_nxt  = byte_in[FMR_THR_W-1:0];
          default:           config_nxt   = config_r;
        endcase
      end
    end
  end

  // Register file and fault state registers.
  always_ff @(posedge CLK)
  begin
    status_r   <= status_nxt;
    config_r   <= config_nxt;
    warn_thr_r <= warn_thr_nxt;
    cut_thr_r  <= cut_thr_nxt;
    power_d_r  <= power_d_nxt;
    hot_warn_r <= hot_warn_nxt;
    hot_cut_r  <= hot_cut_nxt;
    shutdown_r <= shutdown_nxt;
  end

  // Outputs; the interrupt is a level held while any enabled flag is set.
  assign INTERRUPT   = |(status_r & config_r);
  assign SHUTDOWN    = shutdown_r;
  assign SPI_DOUT    = dout_r;
  assign SPI_DOUT_OE = ~cs_n_s;

endmodule

`default_nettype wire

// ---- verification/fmr_checker_assertions.sv ----
// Port-level checks for the fault monitor.
// Assumes a bind onto fmr_fault_monitor in the bench top file.
`timescale 1ns/1ps
`default_nettype none

module fmr_checker
  import fmr_pkg::*;
(
  // Clock, reset and enable.
  input wire logic                 CLK,
  input wire logic                 RESETN,
  input wire logic                 CE,
  // Serial port.
  input wire logic                 SPI_CSZ_N,
  input wire logic                 SPI_CLK,
  input wire logic                 SPI_DOUT,
  input wire logic                 SPI_DOUT_OE,
  // Protection.
  input wire logic [FMR_THR_W-1:0] INPUT_LEVEL,
  input wire logic                 HOT_CUT_TRIP,
  input wire logic                 SHUTDOWN
);
  logic [1:0] up_r;
  logic [1:0] up_nxt;
  logic [5:0] cause_r;
  logic [5:0] cause_nxt;
  logic       live;

  // Synchroniser history must be clean before its output is judged.
  always_comb
  begin
    up_nxt    = (up_r == 2'h3) ? up_r : up_r + 2'h1;
    cause_nxt = {cause_r[4:0], HOT_CUT_TRIP | (INPUT_LEVEL != 5'h1F)};
    if (!RESETN || !CE)
    begin
      up_nxt = 2'h0;
    end
  end

  // Registers of the helper logic.
  always_ff @(posedge CLK)
  begin
    up_r    <= up_nxt;
    cause_r <= cause_nxt;
  end

  assign live = (up_r == 2'h3);

  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);

  // A cutoff trip held long enough to pass the synchroniser.
  sequence hot_held;
    (live && HOT_CUT_TRIP) [*3];
  endsequence

  // A settled serial high phase, long after the preceding fall.
  sequence clk_high;
    (live && SPI_CLK && SPI_DOUT_OE) [*6];
  endsequence

  oe_lag_a: assert property (live |-> SPI_DOUT_OE == !$past(SPI_CSZ_N, 2))
    else $error("output enable does not track chip select");
  oe_on_a: assert property ($fell(SPI_CSZ_N) |-> ##2 SPI_DOUT_OE)
    else $error("output enable late after select");
  oe_off_a: assert property ($rose(SPI_CSZ_N) |-> ##2 !SPI_DOUT_OE)
    else $error("output enable stays after deselect");
  rst_quiet_a: assert property ($rose(RESETN) |-> !SHUTDOWN && !SPI_DOUT_OE)
    else $error("outputs active after reset");
  shut_hold_a: assert property ($past(SHUTDOWN) && $past(RESETN) |-> SHUTDOWN)
    else $error("shutdown released without reset");
  hot_shut_a: assert property (hot_held |=> ##[0:4] SHUTDOWN)
    else $error("no shutdown after cutoff trip");
  shut_cause_a: assert property ($rose(SHUTDOWN) |-> |cause_r)
    else $error("shutdown without a cause");
  dout_hold_a: assert property (clk_high |-> $stable(SPI_DOUT))
    else $error("serial output moved in high phase");
endmodule

`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench: serial register access and fault stimulus.
// Assumes fmr_pkg, the design and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb import fmr_pkg::*;;
  logic                 clk;
  logic                 resetn;
  logic                 ce;
  logic                 csz_n;
  logic                 sclk;
  logic                 din;
  logic [3:0]           flt;
  logic [3:0]           hot;
  logic [FMR_THR_W-1:0] lvl;
  logic                 dout;
  logic                 dout_oe;
  logic                 irq;
  logic                 shut;
  int                   error_cnt;
  int                   n_tests;

  // Core clock, 10 ns period.
  always #5 clk = ~clk;

  // Clock enable is driven so that one scenario can freeze the block.
  fmr_fault_monitor fmr_fault_monitor_inst (
    .CLK              (clk),
    .RESETN           (resetn),
    .CE               (ce),
    .SPI_CSZ_N        (csz_n),
    .SPI_CLK          (sclk),
    .SPI_DIN          (din),
    .SPI_DOUT         (dout),
    .SPI_DOUT_OE      (dout_oe),
    .SUPPLY_FAULT_IN  (flt[0]),
    .ILLUM_FAULT_IN   (flt[1]),
    .MIRROR_FAULT_IN  (flt[2]),
    .POWER_REQUEST_PIN(flt[3]),
    .INPUT_LEVEL      (lvl),
    .HOT_WARN_TRIP    (hot[0]),
    .HOT_WARN_RELEASE (hot[1]),
    .HOT_CUT_TRIP     (hot[2]),
    .HOT_CUT_RELEASE  (hot[3]),
    .INTERRUPT        (irq),
    .SHUTDOWN         (shut)
  );

  // All stimulus moves on the falling edge, away from sampling.
  task automatic gap(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // One 16-bit frame; low phases of 5 cycles let the output settle.
  task automatic spi(input logic [7:0] c, input logic [7:0] w,
                     output logic [7:0] r);
    logic [15:0] f;
    f = {c, w};
    csz_n = 1'b0;
    gap(5);
    for (int i = 15; i >= 0; i--)
    begin
      din = f[i];
      gap(5);
      if (i < 8)
      begin
        r[i] = dout;
      end
      sclk = 1'b1;
      gap(7);
      sclk = 1'b0;
    end
    gap(5);
    csz_n = 1'b1;
    gap(5);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    spi({1'b1, a}, d, r);
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] r;
    spi({1'b0, a}, 8'h00, r);
    chk(r, e);
  endtask

  task automatic rst();
    resetn = 1'b0;
    gap(16);
    resetn = 1'b1;
    gap(2);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
    begin
      $display("*** PASS ***");
    end
    else
    begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Main sequence: reset values, access kinds, then each fault source.
  initial
  begin
    clk = 1'b0;
    ce = 1'b1;
    csz_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
    flt = 4'h0;
    hot = 4'hA;
    lvl = 5'h1F;
    error_cnt = 0;
    n_tests = 0;
    rst();
    chk({6'h00, shut, irq}, 8'h00);
    rd(FMR_ADDR_STATUS, 8'h00);
    rd(FMR_ADDR_CONFIG, 8'hFF);
    rd(FMR_ADDR_WARN_THR, 8'h14);
    rd(FMR_ADDR_CUT_THR, 8'h10);
    wr(FMR_ADDR_CONFIG, 8'h5A);
    rd(FMR_ADDR_CONFIG, 8'h5A);
    wr(FMR_ADDR_WARN_THR, 8'hFF);
    rd(FMR_ADDR_WARN_THR, 8'h1F);
    wr(FMR_ADDR_CUT_THR, 8'hE3);
    rd(FMR_ADDR_CUT_THR, 8'h03);
    wr(7'h20, 8'h77);
    rd(7'h20, 8'h00);
    // Warning level above cutoff, as software is expected to program it.
    wr(FMR_ADDR_WARN_THR, 8'h14);
    wr(FMR_ADDR_CUT_THR, 8'h10);
    // A masked source is recorded but must not interrupt.
    wr(FMR_ADDR_CONFIG, 8'hFE);
    flt[0] = 1'b1;
    gap(6);
    chk({7'h00, irq}, 8'h00);
    flt[0] = 1'b0;
    rd(FMR_ADDR_STATUS, 8'h01);
    wr(FMR_ADDR_CONFIG, 8'hFF);
    // Pulse each block fault and the power request, one at a time.
    for (int i = 0; i < 4; i++)
    begin
      flt[i] = 1'b1;
      gap(6);
      flt[i] = 1'b0;
      gap(6);
      chk({7'h00, irq}, 8'h01);
      rd(FMR_ADDR_STATUS, 8'(8'h01 << i));
      chk({7'h00, irq}, 8'h00);
    end
    // Low input: strict compare, sticky flag, then cutoff.
    lvl = 5'h14;
    gap(6);
    rd(FMR_ADDR_STATUS, 8'h00);
    lvl = 5'h13;
    gap(6);
    rd(FMR_ADDR_STATUS, 8'h10);
    chk({7'h00, shut}, 8'h00);
    lvl = 5'h1F;
    gap(6);
    rd(FMR_ADDR_STATUS, 8'h10);
    rd(FMR_ADDR_STATUS, 8'h00);
    lvl = 5'h0F;
    gap(6);
    chk({7'h00, shut}, 8'h01);
    rd(FMR_ADDR_STATUS, 8'h30);
    lvl = 5'h1F;
    rst();
    // Warning holds between trip and release points.
    hot = 4'h9;
    gap(6);
    hot = 4'h8;
    gap(6);
    rd(FMR_ADDR_STATUS, 8'h40);
    rd(FMR_ADDR_STATUS, 8'h40);
    hot = 4'hA;
    gap(6);
    rd(FMR_ADDR_STATUS, 8'h40);
    rd(FMR_ADDR_STATUS, 8'h00);
    chk({7'h00, shut}, 8'h00);
    hot = 4'h5;
    gap(6);
    hot = 4'h0;
    gap(6);
    chk({7'h00, shut}, 8'h01);
    rd(FMR_ADDR_STATUS, 8'hC0);
    hot = 4'hA;
    rst();
    chk({7'h00, shut}, 8'h00);
    // A fault pulse while the clock enable is low must leave no trace.
    ce = 1'b0;
    flt[0] = 1'b1;
    gap(6);
    flt[0] = 1'b0;
    gap(2);
    ce = 1'b1;
    gap(6);
    chk({7'h00, irq}, 8'h00);
    rd(FMR_ADDR_STATUS, 8'h00);
    print_verdict();
  end
endmodule

bind fmr_fault_monitor fmr_checker fmr_checker_inst (
  .CLK         (CLK),
  .RESETN      (RESETN),
  .CE          (CE),
  .SPI_CSZ_N   (SPI_CSZ_N),
  .SPI_CLK     (SPI_CLK),
  .SPI_DOUT    (SPI_DOUT),
  .SPI_DOUT_OE (SPI_DOUT_OE),
  .INPUT_LEVEL (INPUT_LEVEL),
  .HOT_CUT_TRIP(HOT_CUT_TRIP),
  .SHUTDOWN    (SHUTDOWN)
);

`default_nettype wire
